// ==== hdl/sbw_top.sv ====
// Top: register port and the upward and downward bus weight arbiters
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
// Behaviour
// - down-to-up weight bits 7:0, reset 01
// - peer weight bits 15:8, reloads current
// - up-to-self weight bits 23:16, reloads current
// - down-to-self weight bits 31:24, reloads current
// - upward current counts readable, reset 01
// - up-to-down weight bits 7:0, reset 01
// - decoupler weight bits 15:8, upper reserved
// - downward current counts readable, reset 01
module sbw_top
    import sbw_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Upward bus requests: 0 down-up, 1 peer, 2 up-self, 3 down-self
    input  wire logic [3:0]  up_req,
    output logic      [3:0]  up_grant,
    // Downward bus requests: 0 up-down, 1 decoupler queue
    input  wire logic [1:0]  down_req,
    output logic      [1:0]  down_grant
);

    // ------------------------------------------------------------
    // Programmed counts
    // ------------------------------------------------------------
    logic [31:0] up_prog_reg;
    logic [15:0] down_prog_reg;
    logic [31:0] up_remaining;
    logic [15:0] down_remaining;
    logic [31:0] rdata_next;
    wire         wr_up   = reg_wr && reg_addr == UP_PROG_OFFSET;
    wire         wr_down = reg_wr && reg_addr == DOWN_PROG_OFFSET;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            up_prog_reg <= UP_PROG_RESET;
        end else if (wr_up) begin
            up_prog_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            down_prog_reg <= DOWN_RESET;
        end else if (wr_down) begin
            down_prog_reg <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------
    function automatic logic [7:0] field_of(input logic [31:0] word, input int idx);
        return word[idx*8 +: 8];
    endfunction : field_of

    logic [7:0] down_to_up_weight;
    logic [7:0] peer_weight;
    logic [7:0] up_to_self_weight;
    logic [7:0] down_to_self_weight;
    logic [7:0] up_to_down_weight;
    logic [7:0] decoupler_queue_weight;
    logic [7:0] down_to_up_remaining;
    logic [7:0] peer_remaining;
    logic [7:0] up_to_self_remaining;
    logic [7:0] down_to_self_remaining;
    logic [7:0] up_to_down_remaining;
    logic [7:0] decoupler_queue_remaining;

    assign down_to_up_weight         = field_of(up_prog_reg, 0);
    assign peer_weight               = field_of(up_prog_reg, 1);
    assign up_to_self_weight         = field_of(up_prog_reg, 2);
    assign down_to_self_weight       = field_of(up_prog_reg, 3);
    assign up_to_down_weight         = field_of({16'h0000, down_prog_reg}, 0);
    assign decoupler_queue_weight    = field_of({16'h0000, down_prog_reg}, 1);
    assign down_to_up_remaining      = field_of(up_remaining, 0);
    assign peer_remaining            = field_of(up_remaining, 1);
    assign up_to_self_remaining      = field_of(up_remaining, 2);
    assign down_to_self_remaining    = field_of(up_remaining, 3);
    assign up_to_down_remaining      = field_of({16'h0000, down_remaining}, 0);
    assign decoupler_queue_remaining = field_of({16'h0000, down_remaining}, 1);

    logic [3:0] up_live;
    logic [1:0] down_live;
    logic       up_period_end;
    logic       down_period_end;

    assign up_live         = {down_to_self_remaining != 8'h00, up_to_self_remaining != 8'h00,
                              peer_remaining != 8'h00, down_to_up_remaining != 8'h00};
    assign down_live       = {decoupler_queue_remaining != 8'h00, up_to_down_remaining != 8'h00};
    assign up_period_end   = (up_req != 4'h0) && ((up_req & up_live) == 4'h0);
    assign down_period_end = (down_req != 2'h0) && ((down_req & down_live) == 2'h0);

    // ------------------------------------------------------------
    // Arbiters
    // ------------------------------------------------------------
    sbw_arbiter #(.N(UP_CLASSES)) u_up (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .req       (up_req),
        .weights   (up_prog_reg),
        .grant_reg (up_grant),
        .remaining (up_remaining)
    );

    sbw_arbiter #(.N(DOWN_CLASSES)) u_down (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .req       (down_req),
        .weights   (down_prog_reg),
        .grant_reg (down_grant),
        .remaining (down_remaining)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            UP_PROG_OFFSET:   rdata_next = up_prog_reg;
            UP_CUR_OFFSET:    rdata_next = {down_to_self_remaining, up_to_self_remaining,
                                            peer_remaining, down_to_up_remaining};
            DOWN_PROG_OFFSET: rdata_next = {16'h0000, down_prog_reg};
            DOWN_CUR_OFFSET:  rdata_next = {16'h0000, decoupler_queue_remaining,
                                            up_to_down_remaining};
            default:          rdata_next = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= READ_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= READ_UNMAPPED;
        end
    end

    up_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_up |=> up_prog_reg == $past(reg_wdata))
        else $error("upward weights not written");

    down_reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == DOWN_PROG_OFFSET) |=> reg_rdata[31:16] == 16'h0000)
        else $error("reserved downward bits not zero");

    cur_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == UP_CUR_OFFSET) |=> reg_rdata == $past(up_remaining))
        else $error("upward current count read wrong");

    down_cur_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == DOWN_CUR_OFFSET) |=> reg_rdata[15:0] == $past(down_remaining))
        else $error("downward current count read wrong");

    down_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_down |=> down_prog_reg == $past(reg_wdata[15:0]))
        else $error("downward weights not written");

    // ------------------------------------------------------------
    // Period checks
    // ------------------------------------------------------------
    sequence up_end_s;
        up_period_end;
    endsequence

    sequence down_end_s;
        down_period_end;
    endsequence

    down_up_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_end_s |=> down_to_up_remaining == $past(down_to_up_weight))
        else $error("down-to-up count not reloaded");

    peer_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_end_s |=> peer_remaining == $past(peer_weight))
        else $error("peer count not reloaded");

    up_self_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_end_s |=> up_to_self_remaining == $past(up_to_self_weight))
        else $error("up-to-self count not reloaded");

    down_self_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_end_s |=> down_to_self_remaining == $past(down_to_self_weight))
        else $error("down-to-self count not reloaded");

    up_down_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        down_end_s |=> up_to_down_remaining == $past(up_to_down_weight))
        else $error("up-to-down count not reloaded");

    queue_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        down_end_s |=> decoupler_queue_remaining == $past(decoupler_queue_weight))
        else $error("decoupler count not reloaded");

    down_up_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_grant[0] |-> down_to_up_remaining == $past(down_to_up_remaining) - 8'h01)
        else $error("down-to-up count did not drop");

    peer_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_grant[1] |-> peer_remaining == $past(peer_remaining) - 8'h01)
        else $error("peer count did not drop");

    up_self_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_grant[2] |-> up_to_self_remaining == $past(up_to_self_remaining) - 8'h01)
        else $error("up-to-self count did not drop");

    down_self_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_grant[3] |-> down_to_self_remaining == $past(down_to_self_remaining) - 8'h01)
        else $error("down-to-self count did not drop");

    up_down_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        down_grant[0] |-> up_to_down_remaining == $past(up_to_down_remaining) - 8'h01)
        else $error("up-to-down count did not drop");

    queue_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        down_grant[1] |-> decoupler_queue_remaining == $past(decoupler_queue_remaining) - 8'h01)
        else $error("decoupler count did not drop");

    up_prog_reset_a: assert property (@(posedge ref_clk)
        rst |=> up_prog_reg == UP_PROG_RESET)
        else $error("upward weights not at reset value");

    down_prog_reset_a: assert property (@(posedge ref_clk)
        rst |=> down_prog_reg == DOWN_RESET)
        else $error("downward weights not at reset value");

    up_cur_reset_a: assert property (@(posedge ref_clk)
        rst |=> up_remaining == {4{WEIGHT_RESET}})
        else $error("upward counts not at reset value");

    down_cur_reset_a: assert property (@(posedge ref_clk)
        rst |=> down_remaining == DOWN_RESET)
        else $error("downward counts not at reset value");

    up_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_end_s |=> up_grant == 4'h0)
        else $error("upward grant during reload");

    down_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        down_end_s |=> down_grant == 2'h0)
        else $error("downward grant during reload");

    up_grant_req_a: assert property (@(posedge ref_clk) disable iff (rst)
        (up_grant & ~$past(up_req)) == 4'h0)
        else $error("upward grant without request");

    down_grant_req_a: assert property (@(posedge ref_clk) disable iff (rst)
        (down_grant & ~$past(down_req)) == 2'h0)
        else $error("downward grant without request");

    up_cur_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_wr && reg_addr == UP_CUR_OFFSET && up_req == 4'h0) |=> $stable(up_remaining))
        else $error("upward counts changed by write");

    down_cur_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_wr && reg_addr == DOWN_CUR_OFFSET && down_req == 2'h0) |=> $stable(down_remaining))
        else $error("downward counts changed by write");

    rd_idle_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == READ_UNMAPPED)
        else $error("read data outside read cycle");

endmodule : sbw_top

// ==== hdl/sbw_pkg.sv ====
// Package: register map, field layout and types for the bus transfer weights block
package sbw_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] UP_PROG_OFFSET   = 12'h0458;
    localparam logic [11:0] UP_CUR_OFFSET    = 12'h045C;
    localparam logic [11:0] DOWN_PROG_OFFSET = 12'h0460;
    localparam logic [11:0] DOWN_CUR_OFFSET  = 12'h0464;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          WEIGHT_W      = 8;
    localparam int          UP_CLASSES    = 4;
    localparam int          DOWN_CLASSES  = 2;
    localparam logic [7:0]  WEIGHT_RESET  = 8'h01;
    localparam logic [31:0] UP_PROG_RESET = 32'h0101_0101;
    localparam logic [15:0] DOWN_RESET    = 16'h0101;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } sbw_bus_req_type;

    typedef enum logic [1:0] {
        ARB_IDLE  = 2'b00,
        ARB_GRANT = 2'b01,
        ARB_RELOAD = 2'b10
    } sbw_arb_state_type;

endpackage : sbw_pkg

// ==== hdl/sbw_counter_bank.sv ====
// Counter bank: per-class remaining counts reloaded at end of period
`timescale 1ns/100ps
module sbw_counter_bank
    import sbw_pkg::*;
#(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Control
    input  wire logic [N-1:0]       dec,
    input  wire logic               reload,
    input  wire logic [N*8-1:0]     weights,
    // State
    output logic      [N*8-1:0]     remaining
);

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            remaining <= {N{WEIGHT_RESET}};
        end else begin
            for (int i = 0; i < N; i++) begin
                if (reload) begin
                    remaining[i*8 +: 8] <= weights[i*8 +: 8];
                end else if (dec[i] && remaining[i*8 +: 8] != 8'h00) begin
                    remaining[i*8 +: 8] <= remaining[i*8 +: 8] - 8'h01;
                end
            end
        end
    end

endmodule : sbw_counter_bank

// ==== hdl/sbw_arbiter.sv ====
// Weighted fixed-priority arbiter, lowest eligible index first, driven by a counter bank
`timescale 1ns/100ps
module sbw_arbiter
    import sbw_pkg::*;
#(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst,
    // Requests and weights
    input  wire logic [N-1:0]   req,
    input  wire logic [N*8-1:0] weights,
    // Grant and counts
    output logic      [N-1:0]   grant_reg,
    output logic      [N*8-1:0] remaining
);

    // ------------------------------------------------------------
    // Eligibility
    // ------------------------------------------------------------
    logic [N-1:0] eligible;
    logic [N-1:0] grant_next;
    logic         reload;
    logic [N-1:0] dec;

    always_comb begin
        for (int k = 0; k < N; k++) begin
            eligible[k] = req[k] && (remaining[k*8 +: 8] != 8'h00);
        end
    end

    assign reload = (req != '0) && (eligible == '0);

    always_comb begin
        grant_next = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (eligible[k]) begin
                grant_next = '0;
                grant_next[k] = 1'b1;
            end
        end
    end

    assign dec = grant_next;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            grant_reg <= '0;
        end else begin
            grant_reg <= grant_next;
        end
    end

    sbw_counter_bank #(.N(N)) u_bank (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .dec       (dec),
        .reload    (reload),
        .weights   (weights),
        .remaining (remaining)
    );

    grant_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
        (grant_next[0] && !reload) |=> remaining[7:0] == $past(remaining[7:0]) - 8'h01)
        else $error("granted class count did not drop");

    period_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        reload |=> remaining == $past(weights))
        else $error("counters not reloaded at period end");

    one_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot0(grant_reg))
        else $error("more than one grant");

endmodule : sbw_arbiter

// ==== tb/sbw_req_model.sv ====
// Requester model: pending transfers per class held as level requests
`timescale 1ns/100ps
module sbw_req_model
    import sbw_pkg::*;
#(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst,
    // Load of pending transfers
    input  wire logic           start,
    input  wire logic [N*8-1:0] amount,
    // Bus handshake
    input  wire logic [N-1:0]   grant,
    output logic      [N-1:0]   req
);
    logic [7:0] pending_reg [N];
    // Request drops in the cycle that grants the last pending transfer
    always_comb begin
        for (int i = 0; i < N; i++) begin
            req[i] = pending_reg[i] > {7'h00, grant[i]};
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        for (int i = 0; i < N; i++) begin
            if (rst) begin
                pending_reg[i] <= 8'h00;
            end else if (start) begin
                pending_reg[i] <= amount[i*8 +: 8];
            end else if (grant[i] && pending_reg[i] != 8'h00) begin
                pending_reg[i] <= pending_reg[i] - 8'h01;
            end
        end
    end
endmodule : sbw_req_model

// ==== tb/sbw_top_test.sv ====
// Testbench: register access and weighted grant checks
`timescale 1ns/100ps
module sbw_top_test
    import sbw_pkg::*;
();
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  up_req, up_grant;
    logic [1:0]  down_req, down_grant;
    logic        up_start = 1'b0;
    logic        down_start = 1'b0;
    logic [31:0] up_amount = 32'h0000_0000;
    logic [15:0] down_amount = 16'h0000;
    int          err_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          up_acc[4], up_last[4], dn_acc[2], dn_last[2];
    int          up_done = 0;
    int          dn_done = 0;
    int          up_exp[4] = '{4, 3, 2, 1};
    int          dn_exp[2] = '{2, 3};

    always #12.5 ref_clk = ~ref_clk;

    sbw_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .up_req(up_req),
        .up_grant(up_grant), .down_req(down_req), .down_grant(down_grant));
    sbw_req_model #(.N(4)) up_model (.ref_clk(ref_clk), .rst(rst), .start(up_start),
        .amount(up_amount), .grant(up_grant), .req(up_req));
    sbw_req_model #(.N(2)) down_model (.ref_clk(ref_clk), .rst(rst), .start(down_start),
        .amount(down_amount), .grant(down_grant), .req(down_req));

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [11:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [11:0] addr, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask : reg_read

    // Cycle ceiling
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end

    // Grants per class over one whole arbitration period
    always @(posedge ref_clk) begin
        if (up_start) up_acc = '{default: 0};
        if (down_start) dn_acc = '{default: 0};
        for (int i = 0; i < 4; i++) if (up_grant[i]) up_acc[i]++;
        for (int i = 0; i < 2; i++) if (down_grant[i]) dn_acc[i]++;
        if (up_grant == 4'h0 && up_req != 4'h0 && up_acc.sum() != 0) begin
            up_last = up_acc;
            up_acc = '{default: 0};
            up_done++;
        end
        if (down_grant == 2'h0 && down_req != 2'h0 && dn_acc.sum() != 0) begin
            dn_last = dn_acc;
            dn_acc = '{default: 0};
            dn_done++;
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        reg_read(UP_PROG_OFFSET, 32'h0101_0101);
        reg_read(UP_CUR_OFFSET, 32'h0101_0101);
        reg_read(DOWN_PROG_OFFSET, 32'h0000_0101);
        reg_read(DOWN_CUR_OFFSET, 32'h0000_0101);
        reg_write(12'h0468, 32'hFFFF_FFFF);
        reg_read(12'h0468, 32'h0000_0000);
        reg_write(UP_PROG_OFFSET, 32'h0102_0304);
        reg_read(UP_PROG_OFFSET, 32'h0102_0304);
        reg_write(DOWN_PROG_OFFSET, 32'hA5A5_0302);
        reg_read(DOWN_PROG_OFFSET, 32'h0000_0302);
        @(posedge ref_clk);
        up_amount <= 32'h0101_0101;
        down_amount <= 16'h0101;
        up_start <= 1'b1;
        down_start <= 1'b1;
        @(posedge ref_clk);
        up_start <= 1'b0;
        down_start <= 1'b0;
        @(posedge ref_clk);
        for (int k = 0; k < 20 && (up_req != 4'h0 || down_req != 2'h0); k++) @(posedge ref_clk);
        reg_read(UP_CUR_OFFSET, 32'h0000_0000);
        reg_read(DOWN_CUR_OFFSET, 32'h0000_0000);
        reg_write(UP_CUR_OFFSET, 32'hFFFF_FFFF);
        reg_write(DOWN_CUR_OFFSET, 32'hFFFF_FFFF);
        reg_read(UP_CUR_OFFSET, 32'h0000_0000);
        reg_read(DOWN_CUR_OFFSET, 32'h0000_0000);
        @(posedge ref_clk);
        up_amount <= 32'hC8C8_C8C8;
        down_amount <= 16'hC8C8;
        up_start <= 1'b1;
        down_start <= 1'b1;
        @(posedge ref_clk);
        up_start <= 1'b0;
        down_start <= 1'b0;
        for (int k = 0; k < 200 && (up_done < 1 || dn_done < 1); k++) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) check("up_count", up_last[i], up_exp[i]);
        for (int i = 0; i < 2; i++) check("down_count", dn_last[i], dn_exp[i]);
        print_verdict();
    end
endmodule : sbw_top_test
